// ### fallback_regs_params.svh
/*
  Constants for the fallback-mode configuration registers: register
  offsets, field widths, reset values and soft reset command codes.
  Assumes it is included by bare name, once per compile unit or more.
*/
`ifndef FALLBACK_REGS_PARAMS_SVH
`define FALLBACK_REGS_PARAMS_SVH

// register offsets on the serial register port
`define ADR_CH1_DIM_LO 6'h28
`define ADR_CH1_DIM_HI 6'h29
`define ADR_CH2_DIM_LO 6'h2A
`define ADR_CH2_DIM_HI 6'h2B
`define ADR_CH1_ON_TIME 6'h2C
`define ADR_CH2_ON_TIME 6'h2D
`define ADR_SOFT_RESET 6'h2E

// field widths, all fields start at bit 0
`define REG_ADDR_W 6
`define REG_DATA_W 8
`define DIM_LO_W 8
`define DIM_HI_W 2
`define ON_TIME_W 6

// reset values
`define DIM_LO_RST 8'h00
`define DIM_HI_RST 2'h0
`define ON_TIME_RST 6'h07
`define WDT_EN_RST 1'b0
`define PC_IND_RST 1'b1

// soft reset command codes
`define CMD_RESET_LOAD 8'hC3
`define CMD_RESET_DETECT 8'hD4

`endif

// ### fallback_pkg.sv
/*
  Types shared by the fallback-mode register bank.
  Assumes the params header sits in the same folder.
*/
`default_nettype none
package fallback_pkg;
  `include "fallback_regs_params.svh"

  typedef logic [`REG_ADDR_W-1:0] reg_addr_t;
  typedef logic [`REG_DATA_W-1:0] reg_byte_t;

  // accepted soft reset commands
  typedef enum logic [7:0] {
    CMD_LOAD = `CMD_RESET_LOAD,
    CMD_DETECT = `CMD_RESET_DETECT
  } soft_cmd_e;
endpackage
`default_nettype wire

// ### field_wr_if.sv
/*
  Write bundle from the register decoder to each storage field.
  Assumes one driver (the decoder) and any number of fields.
*/
`default_nettype none
interface field_wr_if;
  logic ce;
  logic we;
  logic soft_clr;
  fallback_pkg::reg_byte_t wdata;

  modport src(output ce, output we, output soft_clr, output wdata);
  modport dst(input ce, input we, input soft_clr, input wdata);
endinterface
`default_nettype wire

// ### cfg_field.sv
/*
  One writable configuration field of W bits at bit 0 of its register.
  Assumes the decoder raises sel only for this field's own address.
*/
`default_nettype none
module cfg_field #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic rst,
  field_wr_if.dst wr,
  input wire logic sel,
  output logic [W-1:0] q
);

  // soft clear has priority; upper write bits are dropped on purpose
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= RST;
    end else if (wr.ce) begin
      if (wr.soft_clr) begin
        q <= RST;
      end else if (wr.we && sel) begin
        q <= wr.wdata[W-1:0]; // RULE_03
      end
    end
  end
endmodule
`default_nettype wire

// ### fallback_regs.sv
/*
  Fallback-mode configuration register bank of a dual-channel LED
  driver: dimming widths, on-time fields and the soft reset command.
  Assumes the serial interface logic outside turns each frame into a
  one-cycle read or write strobe with address and data on this port.
*/
// Contract
// [RULE_01] ch1 dim width upper two bits live in bits 1-0 at 0x29.
// [RULE_02] ch2 dim width: low byte at 0x2A, upper two bits at 0x2B.
// [RULE_03] reserved upper bits read zero and ignore writes.
// [RULE_04] ch1 six-bit on-time field at 0x2C sets fallback frequency.
// [RULE_05] ch2 six-bit on-time field at 0x2D sets fallback frequency.
// [RULE_06] both on-time fields reset to 0x07.
// [RULE_07] all dim width bytes reset to zero.
// [RULE_08] write-only soft reset command register at 0x2E.
// [RULE_09] soft reset leaves the power-cycle indicator alone.
// [RULE_10] 0xC3 restores defaults, machines to load, watchdog off.
// [RULE_11] 0xD4 restores defaults, watchdog on, detect if timeouts clear.
// [RULE_12] reading the soft reset register returns zero.
`default_nettype none
`include "fallback_regs_params.svh"
module fallback_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire fallback_pkg::reg_addr_t reg_addr,
  input wire fallback_pkg::reg_byte_t reg_wdata,
  output fallback_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire logic standalone_mode,
  input wire logic [1:0] watchdog_timeout_bits,
  input wire logic pc_clear,
  output logic [9:0] ch1_fallback_dim_width,
  output logic [9:0] ch2_fallback_dim_width,
  output logic [5:0] ch1_fallback_on_time_field,
  output logic [5:0] ch2_fallback_on_time_field,
  output logic watchdog_en,
  output logic sm_to_load,
  output logic sm_to_detect,
  output logic power_cycle_indicator
);

  field_wr_if wr ();

  logic [`DIM_LO_W-1:0] ch1_lo;
  logic [`DIM_HI_W-1:0] ch1_hi;
  logic [`DIM_LO_W-1:0] ch2_lo;
  logic [`DIM_HI_W-1:0] ch2_hi;
  logic [`ON_TIME_W-1:0] on1;
  logic [`ON_TIME_W-1:0] on2;
  logic cmd_wr;
  logic cmd_load;
  logic cmd_detect;
  fallback_pkg::reg_byte_t rdata_d;
  fallback_pkg::reg_byte_t rdata_q;
  logic rvalid_q;
  logic wdt_en_q;
  logic to_load_q;
  logic to_detect_q;
  logic pc_ind_q;

  // soft reset decode; any other value written to 0x2E is ignored
  assign cmd_wr = reg_wr && (reg_addr == `ADR_SOFT_RESET); // RULE_08
  assign cmd_load = cmd_wr &&
    (reg_wdata == fallback_pkg::CMD_LOAD); // RULE_10
  assign cmd_detect = cmd_wr &&
    (reg_wdata == fallback_pkg::CMD_DETECT); // RULE_11

  // the command register has no storage: it only fans out a clear
  assign wr.ce = ce;
  assign wr.we = reg_wr;
  assign wr.wdata = reg_wdata;
  assign wr.soft_clr = cmd_load || cmd_detect; // RULE_10 RULE_11

  // dimming width bytes, cleared at reset and by soft reset
  cfg_field #(.W(`DIM_LO_W), .RST(`DIM_LO_RST)) u_ch1_lo (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH1_DIM_LO),
    .q(ch1_lo)
  ); // RULE_07
  cfg_field #(.W(`DIM_HI_W), .RST(`DIM_HI_RST)) u_ch1_hi (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH1_DIM_HI),
    .q(ch1_hi)
  ); // RULE_01
  cfg_field #(.W(`DIM_LO_W), .RST(`DIM_LO_RST)) u_ch2_lo (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH2_DIM_LO),
    .q(ch2_lo)
  ); // RULE_02
  cfg_field #(.W(`DIM_HI_W), .RST(`DIM_HI_RST)) u_ch2_hi (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH2_DIM_HI),
    .q(ch2_hi)
  ); // RULE_02

  // on-time fields default to the 437 kHz setting
  cfg_field #(.W(`ON_TIME_W), .RST(`ON_TIME_RST)) u_on1 (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH1_ON_TIME),
    .q(on1)
  ); // RULE_04 RULE_06
  cfg_field #(.W(`ON_TIME_W), .RST(`ON_TIME_RST)) u_on2 (
    .mclk(mclk),
    .rst(rst),
    .wr(wr.dst),
    .sel(reg_addr == `ADR_CH2_ON_TIME),
    .q(on2)
  ); // RULE_05 RULE_06

  // assembled values for the fallback pwm and on-time logic
  assign ch1_fallback_dim_width = {ch1_hi, ch1_lo}; // RULE_01
  assign ch2_fallback_dim_width = {ch2_hi, ch2_lo}; // RULE_02
  assign ch1_fallback_on_time_field = on1; // RULE_04
  assign ch2_fallback_on_time_field = on2; // RULE_05

  // read mux; reserved bits and unmapped addresses read as zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `ADR_CH1_DIM_LO: rdata_d = ch1_lo;
      `ADR_CH1_DIM_HI: rdata_d = {6'h00, ch1_hi}; // RULE_01 RULE_03
      `ADR_CH2_DIM_LO: rdata_d = ch2_lo;
      `ADR_CH2_DIM_HI: rdata_d = {6'h00, ch2_hi}; // RULE_03
      `ADR_CH1_ON_TIME: rdata_d = {2'h0, on1}; // RULE_03
      `ADR_CH2_ON_TIME: rdata_d = {2'h0, on2}; // RULE_03
      `ADR_SOFT_RESET: rdata_d = 8'h00; // RULE_12
      default: rdata_d = 8'h00;
    endcase
  end

  // read data is held until the next read so the shifter can take it late
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // read answer strobe, one cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= reg_rd;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // watchdog enable follows the last accepted soft reset command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdt_en_q <= `WDT_EN_RST;
    end else if (ce) begin
      if (cmd_load) begin
        wdt_en_q <= 1'b0; // RULE_10
      end else if (cmd_detect) begin
        wdt_en_q <= 1'b1; // RULE_11
      end
    end
  end

  // one-cycle requests to the stand-alone channel state machines;
  // detect needs the timeout bits already cleared by a status read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      to_load_q <= 1'b0;
      to_detect_q <= 1'b0;
    end else if (ce) begin
      to_load_q <= cmd_load && standalone_mode; // RULE_10
      to_detect_q <= cmd_detect && standalone_mode &&
        (watchdog_timeout_bits == 2'b00); // RULE_11
    end
  end

  // power-cycle indicator: set only by the power-on reset, cleared by a
  // status read; the soft clear deliberately does not reach it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_ind_q <= `PC_IND_RST;
    end else if (ce && pc_clear) begin
      pc_ind_q <= 1'b0; // RULE_09
    end
  end

  assign watchdog_en = wdt_en_q;
  assign sm_to_load = to_load_q;
  assign sm_to_detect = to_detect_q;
  assign power_cycle_indicator = pc_ind_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // a write to a high byte keeps only bits 1-0
  property hi_write_p(adr, logic [1:0] hi);
    ce && reg_wr && reg_addr == adr |=> hi == $past(reg_wdata[1:0]);
  endproperty

  // every accepted write shows on the assembled outputs one edge later
  ch1_hi_write_a: assert property ( // RULE_01
    hi_write_p(`ADR_CH1_DIM_HI, ch1_hi))
    else $error("ch1 high dim bits not written");
  ch1_lo_write_a: assert property ( // RULE_01
    ce && reg_wr && reg_addr == `ADR_CH1_DIM_LO
    |=> ch1_fallback_dim_width[7:0] == $past(reg_wdata))
    else $error("ch1 low dim byte not written");
  ch2_width_write_a: assert property ( // RULE_02
    ce && reg_wr && reg_addr == `ADR_CH2_DIM_LO
    |=> ch2_fallback_dim_width[7:0] == $past(reg_wdata))
    else $error("ch2 low dim byte not written");
  ch2_hi_write_a: assert property ( // RULE_02
    hi_write_p(`ADR_CH2_DIM_HI, ch2_hi))
    else $error("ch2 high dim bits not written");

  // reserved positions read low; high bytes carry six, on-times two
  reserved_read_a: assert property ( // RULE_03
    ce && reg_rd && (reg_addr == `ADR_CH1_ON_TIME ||
      reg_addr == `ADR_CH2_DIM_HI)
    |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
    else $error("reserved bits read non-zero");
  hi_read_zero_a: assert property ( // RULE_03
    ce && reg_rd && (reg_addr == `ADR_CH1_DIM_HI ||
      reg_addr == `ADR_CH2_DIM_HI)
    |=> reg_rdata[7:2] == 6'h00)
    else $error("high byte reserved bits read non-zero");
  on_read_zero_a: assert property ( // RULE_03
    ce && reg_rd && reg_addr == `ADR_CH2_ON_TIME
    |=> reg_rdata[7:6] == 2'b00)
    else $error("on-time reserved bits read non-zero");

  // on-time fields: written value lands, read returns the stored value
  on1_write_a: assert property ( // RULE_04
    ce && reg_wr && reg_addr == `ADR_CH1_ON_TIME
    |=> ch1_fallback_on_time_field == $past(reg_wdata[5:0]))
    else $error("ch1 on-time not written");
  on1_read_a: assert property ( // RULE_04
    ce && reg_rd && reg_addr == `ADR_CH1_ON_TIME
    |=> reg_rdata[5:0] == $past(ch1_fallback_on_time_field))
    else $error("ch1 on-time read back wrong");
  on2_write_a: assert property ( // RULE_05
    ce && reg_wr && reg_addr == `ADR_CH2_ON_TIME
    |=> ch2_fallback_on_time_field == $past(reg_wdata[5:0]))
    else $error("ch2 on-time not written");
  on2_read_a: assert property ( // RULE_05
    ce && reg_rd && reg_addr == `ADR_CH2_ON_TIME
    |=> reg_rdata[5:0] == $past(ch2_fallback_on_time_field))
    else $error("ch2 on-time read back wrong");

  // soft reset commands, and codes that must have no effect at all
  soft_defaults_a: assert property ( // RULE_06 RULE_07
    ce && (cmd_load || cmd_detect)
    |=> ch1_fallback_on_time_field == 6'h07 &&
      ch2_fallback_on_time_field == 6'h07 &&
      ch1_fallback_dim_width == 10'h000 &&
      ch2_fallback_dim_width == 10'h000)
    else $error("soft reset did not restore defaults");
  cmd_read_zero_a: assert property ( // RULE_12
    ce && reg_rd && reg_addr == `ADR_SOFT_RESET |=> reg_rdata == 8'h00)
    else $error("soft reset register read non-zero");
  ignored_cmd_a: assert property ( // RULE_08
    ce && cmd_wr && !cmd_load && !cmd_detect
    |=> $stable(watchdog_en) && $stable(ch1_fallback_dim_width) &&
      $stable(ch2_fallback_dim_width) && !sm_to_load && !sm_to_detect)
    else $error("unknown soft reset code had an effect");
  pc_kept_a: assert property ( // RULE_09
    ce && cmd_wr && !pc_clear
    |=> $stable(power_cycle_indicator))
    else $error("soft reset disturbed power-cycle bit");
  load_cmd_a: assert property ( // RULE_10
    ce && cmd_load |=> !watchdog_en && sm_to_load == $past(standalone_mode)
    ##1 (!sm_to_load || !$past(ce) || $past(cmd_load)))
    else $error("0xC3 effects wrong");
  load_pulse_a: assert property ( // RULE_10
    ce && !cmd_load |=> !sm_to_load)
    else $error("load request without a load command");
  detect_cmd_a: assert property ( // RULE_11
    ce && cmd_detect |=> watchdog_en && !sm_to_load &&
      sm_to_detect == $past(standalone_mode &&
        watchdog_timeout_bits == 2'b00))
    else $error("0xD4 effects wrong");
  detect_pulse_a: assert property ( // RULE_11
    ce && !cmd_detect |=> !sm_to_detect)
    else $error("detect request without a detect command");

  cov_load_c: cover property (ce && cmd_load && standalone_mode);
  cov_detect_c: cover property (ce && cmd_detect ##1 sm_to_detect);
  cov_width_c: cover property (
    ce && reg_wr && reg_addr == `ADR_CH1_DIM_HI ##1
    ce && reg_rd && reg_addr == `ADR_CH1_DIM_HI);
  cov_freeze_c: cover property (!ce && reg_wr);
  cov_ignored_c: cover property (ce && cmd_wr && !cmd_load && !cmd_detect);
endmodule
`default_nettype wire

// ### host_model.sv
/*
  Host side model: issues register writes and reads on the strobe port.
  Assumes the bench calls its tasks at a falling edge of mclk.
*/
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire fallback_pkg::reg_byte_t reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output fallback_pkg::reg_addr_t reg_addr,
  output fallback_pkg::reg_byte_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // one strobe held over the taking edge; released lines show the
  // inverse so a stale value is never mistaken for a fresh one
  task automatic wr(input fallback_pkg::reg_addr_t a,
                    input fallback_pkg::reg_byte_t d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read answer is looked at in the one cycle it stands
  task automatic rd(input fallback_pkg::reg_addr_t a,
                    output fallback_pkg::reg_byte_t d, output logic v);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// ### fallback_regs_bench.sv
/*
  Self-checking bench for the fallback register bank.
  Assumes the host model and the design sources are compiled first.
*/
`default_nettype none
`include "fallback_regs_params.svh"
module fallback_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, ce, reg_wr, reg_rd, reg_rvalid, standalone_mode;
  logic pc_clear, watchdog_en, sm_to_load, sm_to_detect, pc_ind;
  logic [1:0] timeout_bits;
  fallback_pkg::reg_addr_t reg_addr;
  fallback_pkg::reg_byte_t reg_wdata, reg_rdata;
  logic [9:0] ch1_w, ch2_w;
  logic [5:0] ch1_t, ch2_t;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  fallback_regs fallback_regs_i (.mclk(mclk), .rst(rst), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .standalone_mode(standalone_mode), .watchdog_timeout_bits(timeout_bits),
    .pc_clear(pc_clear), .ch1_fallback_dim_width(ch1_w),
    .ch2_fallback_dim_width(ch2_w), .ch1_fallback_on_time_field(ch1_t),
    .ch2_fallback_on_time_field(ch2_t), .watchdog_en(watchdog_en),
    .sm_to_load(sm_to_load), .sm_to_detect(sm_to_detect),
    .power_cycle_indicator(pc_ind));
  host_model host_model_i (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // hang guard, far above the roughly 70 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [9:0] exp,
                     input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input fallback_pkg::reg_addr_t a,
                        input fallback_pkg::reg_byte_t exp);
    fallback_pkg::reg_byte_t d;
    logic v;
    host_model_i.rd(a, d, v);
    chk("rvalid", 10'h001, {9'h000, v});
    chk($sformatf("read %h", a), {2'h0, exp}, {2'h0, d});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // every register reads its reset value, the command register zero
  task automatic sc_reset_values();
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h07, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rd_chk(6'(`ADR_CH1_DIM_LO + i), rv[i]);
    end
    chk("pc", 10'h001, {9'h000, pc_ind});
  endtask
  // distinct patterns catch bit positions and dropped reserved bits
  task automatic sc_write_back();
    logic [7:0] wv [6] = '{8'hA5, 8'hFE, 8'h5A, 8'hFD, 8'hEA, 8'hD5};
    logic [7:0] rv [6] = '{8'hA5, 8'h02, 8'h5A, 8'h01, 8'h2A, 8'h15};
    for (int i = 0; i < 6; i++) begin
      host_model_i.wr(6'(`ADR_CH1_DIM_LO + i), wv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk(6'(`ADR_CH1_DIM_LO + i), rv[i]);
    end
    chk("ch1 width", 10'h2A5, ch1_w);
    chk("ch2 width", 10'h15A, ch2_w);
    chk("ch1 on", 10'h02A, {4'h0, ch1_t});
    chk("ch2 on", 10'h015, {4'h0, ch2_t});
  endtask
  // frozen clock enable and unknown command change nothing; unmapped place reads zero
  task automatic sc_refused();
    ce = 1'b0;
    host_model_i.wr(`ADR_CH1_ON_TIME, 8'h11);
    ce = 1'b1;
    rd_chk(`ADR_CH1_ON_TIME, 8'h2A);
    host_model_i.wr(`ADR_SOFT_RESET, 8'h55);
    chk("ch1 width", 10'h2A5, ch1_w);
    rd_chk(`ADR_SOFT_RESET, 8'h00);
    rd_chk(6'h3F, 8'h00);
  endtask
  // detect only once the timeout bits are clear; watchdog on either way
  task automatic sc_detect();
    standalone_mode = 1'b1;
    timeout_bits = 2'h1;
    host_model_i.wr(`ADR_SOFT_RESET, `CMD_RESET_DETECT);
    chk("wdt", 10'h001, {9'h000, watchdog_en});
    chk("detect", 10'h000, {9'h000, sm_to_detect});
    chk("ch2 on", 10'h007, {4'h0, ch2_t});
    timeout_bits = 2'h0;
    host_model_i.wr(`ADR_CH2_DIM_LO, 8'h33);
    host_model_i.wr(`ADR_SOFT_RESET, `CMD_RESET_DETECT);
    chk("detect", 10'h001, {9'h000, sm_to_detect});
    chk("ch2 width", 10'h000, ch2_w);
    @(negedge mclk);
    chk("detect", 10'h000, {9'h000, sm_to_detect});
  endtask
  // load command after the indicator was cleared must not set it again
  task automatic sc_load();
    @(negedge mclk);
    pc_clear = 1'b1;
    @(negedge mclk);
    pc_clear = 1'b0;
    chk("pc", 10'h000, {9'h000, pc_ind});
    host_model_i.wr(`ADR_CH1_ON_TIME, 8'h3F);
    host_model_i.wr(`ADR_SOFT_RESET, `CMD_RESET_LOAD);
    chk("load", 10'h001, {9'h000, sm_to_load});
    chk("wdt", 10'h000, {9'h000, watchdog_en});
    chk("ch1 on", 10'h007, {4'h0, ch1_t});
    chk("pc", 10'h000, {9'h000, pc_ind});
    @(negedge mclk);
    chk("load", 10'h000, {9'h000, sm_to_load});
    // outside stand-alone mode neither command may reach the machines
    standalone_mode = 1'b0;
    host_model_i.wr(`ADR_SOFT_RESET, `CMD_RESET_LOAD);
    chk("load", 10'h000, {9'h000, sm_to_load});
    host_model_i.wr(`ADR_SOFT_RESET, `CMD_RESET_DETECT);
    chk("detect", 10'h000, {9'h000, sm_to_detect});
    chk("wdt", 10'h001, {9'h000, watchdog_en});
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    standalone_mode = 1'b0;
    timeout_bits = 2'h3;
    pc_clear = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    sc_reset_values();
    sc_write_back();
    sc_refused();
    sc_detect();
    sc_load();
    tally_and_finish();
  end
endmodule
`default_nettype wire
